// ==== lceh_error_handler.sv ====
/*
 Error handler of a multi-channel LED light controller: command plausibility
 check with all-or-nothing commit, overtemperature error mode, channel-number
 supervision, voltage-limit supervision and framed text error reports.
 Assumes synchronous inputs, a host that drains the report stream via
 txReady, and an AXI4-Lite master with one write and one read in flight.
// Overview of operation
// RULE1 - Reports framed as colon-E, text, CRLF, prompt
// RULE2 - Implausible parameter values answered with error report
// RULE3 - Rejected values never reach stored configuration
// RULE4 - Multi-parameter command commits all or nothing
// RULE5 - Current above limit rejected, maximum stated
// RULE6 - Overtemperature cuts that channel's output current
// RULE7 - Overtemperature: error mode, red flashing, report
// RULE8 - Error-mode channel refuses all configuration requests
// RULE9 - Cooling down ends error mode and flashing
// RULE10 - Overtemperature report names two-digit channel number
// RULE11 - Unsolicited reports go to last good interface
// RULE12 - Channel number change while running is error
// RULE13 - Duplicate numbers at power-on: report, flash forever
// RULE14 - Voltage limit too low for current flagged
// RULE15 - Host accepts unsolicited reports at any time
*/
module lceh_error_handler
	import lceh_pkg::*;
#(
	parameter int NCH       = 2,
	parameter int FLASH_CYC = FLASH_CYCLES
)
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [7:0]           awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [7:0]           araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	input  wire lceh_cmd_t            cmdIn,
	input  wire logic                 cmdValid,
	output logic                      cmdReady,
	input  wire logic [NCH-1:0][7:0]  tempC,
	input  wire logic [NCH-1:0][4:0]  chanNumSw,
	input  wire logic [NCH-1:0][15:0] measCurrent,
	input  wire logic [NCH-1:0][15:0] measVolt,
	output lceh_tx_t                  txOut,
	output logic                      txValid,
	input  wire logic                 txReady,
	output logic [NCH-1:0][15:0]      outCurrent,
	output logic [NCH-1:0]            ledRed,
	output logic                      irq
);
	logic [7:0]            awAddr_reg, tLim_reg, tHys_reg;
	logic                  awDone_reg, wDone_reg;
	logic [31:0]           wData_reg;
	logic                  wStrb0_reg;
	logic [EV_W-1:0]       status_reg, status_next, mask_reg, events;
	logic [NCH-1:0][15:0]  curLim_reg, softCur_reg, voltLim_reg;
	logic [NCH-1:0]        errMode_reg, dup_reg, chgSeen_reg, vlCond_reg;
	logic [NCH-1:0][4:0]   capNum_reg;
	logic [1:0]            boot_reg;
	logic [3:0][NCH-1:0]   pend_reg, pend_next, pendSet, pendTake;
	logic                  lastUdp_reg, replyPend_reg, replyUdp_reg;
	lceh_msg_t             replyCode_reg, code_reg, selCode, romCode;
	logic [15:0]           replyArg_reg, arg_reg, selArg;
	logic                  selUdp, selAny, txLast_reg, flash_reg;
	lceh_txst_t            txState_reg;
	logic [5:0]            idx_reg, romIdx;
	logic [7:0]            romCh;
	logic                  romLast;
	logic [31:0]           flashCnt_reg;
	logic                  doWrite, cmdAcc, chanOk, cmdBad, cmdTooBig, cmdErr, cmdOk;
	logic [15:0]           effLimit;
	lceh_msg_t             cmdCode;
	int                    ci;

	function automatic lceh_msg_t classMsg(input int k);
		case (k)
			0:       return MSG_DUP;
			1:       return MSG_OVERTEMP;
			2:       return MSG_CHANCHG;
			default: return MSG_VOLTLOW;
		endcase
	endfunction

	// AXI4-Lite write: address and data taken in either order
	assign doWrite = awDone_reg && wDone_reg;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			awDone_reg <= 1'b0;
			wDone_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h00000000;
			wStrb0_reg <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awready <= 1'b0;
				awDone_reg <= 1'b1;
				awAddr_reg <= awaddr;
			end
			if (wvalid && wready)
			begin
				wready <= 1'b0;
				wDone_reg <= 1'b1;
				wData_reg <= wdata;
				wStrb0_reg <= wstrb[0];
			end
			if (doWrite)
			begin
				awDone_reg <= 1'b0;
				wDone_reg <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (awAddr_reg == ADDR_STATUS || awAddr_reg == ADDR_MASK || awAddr_reg == ADDR_TLIM
					|| awAddr_reg == ADDR_THYS || awAddr_reg == ADDR_STATE) ? 2'h0 : 2'h2;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mask_reg <= 6'h00;
			tLim_reg <= TLIM_RST;
			tHys_reg <= THYS_RST;
		end
		else if (doWrite && wStrb0_reg)
		begin
			if (awAddr_reg == ADDR_MASK)
				mask_reg <= wData_reg[EV_W-1:0];
			if (awAddr_reg == ADDR_TLIM)
				tLim_reg <= wData_reg[7:0];
			if (awAddr_reg == ADDR_THYS)
				tHys_reg <= wData_reg[7:0];
		end
	end

	// Write-one-to-clear; a new event in the same cycle wins
	always_comb
	begin
		status_next = status_reg;
		if (doWrite && wStrb0_reg && awAddr_reg == ADDR_STATUS)
			status_next = status_reg & ~wData_reg[EV_W-1:0];
		status_next = status_next | events;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			status_reg <= 6'h00;
			irq <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			irq <= |(status_reg & mask_reg);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'h0;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= 2'h0;
			rdata <= 32'h00000000;
			case (araddr)
				ADDR_STATUS: rdata[EV_W-1:0] <= status_reg;
				ADDR_MASK:   rdata[EV_W-1:0] <= mask_reg;
				ADDR_TLIM:   rdata[7:0] <= tLim_reg;
				ADDR_THYS:   rdata[7:0] <= tHys_reg;
				ADDR_STATE:
				begin
					rdata[NCH-1:0] <= errMode_reg;
					rdata[8 +: NCH] <= dup_reg;
					rdata[STATE_UDP_BIT] <= lastUdp_reg;
					rdata[STATE_BUSY_BIT] <= (txState_reg == TX_SEND);
				end
				default:     rresp <= 2'h2;
			endcase
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Plausibility check of one command, judged as a whole
	always_comb
	begin
		chanOk = int'(cmdIn.chan) < NCH;
		ci = chanOk ? int'(cmdIn.chan) : 0;
		effLimit = cmdIn.setLimit ? cmdIn.limit : curLim_reg[ci];
		cmdBad = !(cmdIn.setLimit || cmdIn.setCurr || cmdIn.setVolt)
			|| (cmdIn.setLimit && int'(cmdIn.limit) > MAX_CURRENT_MA)
			|| (cmdIn.setVolt && int'(cmdIn.volt) > VOLT_MAX_MV); // RULE2
		cmdTooBig = cmdIn.setCurr && cmdIn.curr > effLimit; // RULE5
		cmdErr = 1'b1;
		cmdCode = MSG_INVALID;
		if (!chanOk)
			cmdCode = MSG_INVALID;
		else if (errMode_reg[ci])
			cmdCode = MSG_ERRMODE; // RULE8
		else if (cmdBad)
			cmdCode = MSG_INVALID;
		else if (cmdTooBig)
			cmdCode = MSG_LIMIT;
		else
			cmdErr = 1'b0;
	end
	assign cmdAcc = cmdValid && cmdReady;
	assign cmdOk = cmdAcc && !cmdErr;

	// Stored configuration only moves on a fully valid command
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			curLim_reg <= '0;
			softCur_reg <= '0;
			voltLim_reg <= {NCH{VOLT_LIM_RST}};
		end
		else if (cmdOk) // RULE3 RULE4
		begin
			if (cmdIn.setLimit)
				curLim_reg[ci] <= cmdIn.limit;
			if (cmdIn.setCurr)
				softCur_reg[ci] <= cmdIn.curr;
			if (cmdIn.setVolt)
				voltLim_reg[ci] <= cmdIn.volt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			replyPend_reg <= 1'b0;
			replyCode_reg <= MSG_INVALID;
			replyArg_reg <= 16'h0000;
			replyUdp_reg <= 1'b0;
			lastUdp_reg <= 1'b0;
			cmdReady <= 1'b0;
		end
		else
		begin
			// One reply slot; commands stall while it is full
			cmdReady <= !(replyPend_reg || (cmdAcc && cmdErr)) || (txState_reg == TX_IDLE && replyPend_reg
				&& !(cmdAcc && cmdErr));
			if (cmdAcc && cmdErr)
			begin
				replyPend_reg <= 1'b1;
				replyCode_reg <= cmdCode;
				replyArg_reg <= effLimit;
				replyUdp_reg <= cmdIn.udp;
			end
			else if (txState_reg == TX_IDLE)
				replyPend_reg <= 1'b0;
			if (cmdOk)
				lastUdp_reg <= cmdIn.udp; // RULE11
		end
	end

	// Channel numbers caught once after reset release
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			boot_reg <= 2'h0;
			capNum_reg <= '0;
		end
		else if (boot_reg != 2'h2)
		begin
			boot_reg <= boot_reg + 2'h1;
			if (boot_reg == 2'h0)
				capNum_reg <= chanNumSw;
		end
	end

	always_comb
	begin
		pendSet = '0;
		events = '0;
		for (int i = 0; i < NCH; i++)
		begin
			if (boot_reg == 2'h1)
			begin
				for (int j = 0; j < NCH; j++)
				begin
					if (j != i && capNum_reg[i] == capNum_reg[j])
						pendSet[0][i] = 1'b1; // RULE13
				end
			end
			pendSet[1][i] = !errMode_reg[i] && tempC[i] > tLim_reg; // RULE7
			pendSet[2][i] = boot_reg == 2'h2 && !chgSeen_reg[i] && chanNumSw[i] != capNum_reg[i]; // RULE12
			pendSet[3][i] = !vlCond_reg[i] && !errMode_reg[i] && !dup_reg[i] && softCur_reg[i] != 16'h0000
				&& {1'b0, measCurrent[i]} + {1'b0, CUR_MARGIN_MA} < {1'b0, softCur_reg[i]}
				&& measVolt[i] >= voltLim_reg[i]; // RULE14
			if (errMode_reg[i] && {1'b0, tempC[i]} + {1'b0, tHys_reg} <= {1'b0, tLim_reg})
				events[EV_COOLED] = 1'b1;
		end
		events[EV_DUP] = |pendSet[0];
		events[EV_OVERTEMP] = |pendSet[1];
		events[EV_CHANCHG] = |pendSet[2];
		events[EV_VOLTLOW] = |pendSet[3];
		events[EV_REJECT] = cmdAcc && cmdErr;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			errMode_reg <= '0;
			dup_reg <= '0;
			chgSeen_reg <= '0;
			vlCond_reg <= '0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (pendSet[1][i])
					errMode_reg[i] <= 1'b1; // RULE6
				else if ({1'b0, tempC[i]} + {1'b0, tHys_reg} <= {1'b0, tLim_reg})
					errMode_reg[i] <= 1'b0; // RULE9
				if (pendSet[0][i])
					dup_reg[i] <= 1'b1;
				if (pendSet[2][i])
					chgSeen_reg[i] <= 1'b1;
				// Widened sum: a full-scale reading must not wrap
				vlCond_reg[i] <= softCur_reg[i] != 16'h0000
					&& {1'b0, measCurrent[i]} + {1'b0, CUR_MARGIN_MA} < {1'b0, softCur_reg[i]}
					&& measVolt[i] >= voltLim_reg[i];
			end
		end
	end

	// Red flashing shared by error mode and duplicate numbers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			flashCnt_reg <= 32'h00000000;
			flash_reg <= 1'b0;
			ledRed <= '0;
			outCurrent <= '0;
		end
		else
		begin
			if (flashCnt_reg == 32'(FLASH_CYC - 1))
			begin
				flashCnt_reg <= 32'h00000000;
				flash_reg <= !flash_reg;
			end
			else
				flashCnt_reg <= flashCnt_reg + 32'h00000001;
			for (int i = 0; i < NCH; i++)
			begin
				ledRed[i] <= (errMode_reg[i] || dup_reg[i]) && flash_reg; // RULE7 RULE9 RULE13
				outCurrent[i] <= (errMode_reg[i] || dup_reg[i]) ? 16'h0000 : softCur_reg[i]; // RULE6
			end
		end
	end

	// Command replies first, then unsolicited events by class
	always_comb
	begin
		pendTake = '0;
		selAny = 1'b0;
		selCode = replyCode_reg;
		selArg = replyArg_reg;
		selUdp = replyUdp_reg;
		if (replyPend_reg)
			selAny = 1'b1;
		else
		begin
			for (int k = 0; k < 4; k++)
			begin
				for (int i = 0; i < NCH; i++)
				begin
					if (!selAny && pend_reg[k][i])
					begin
						selAny = 1'b1;
						pendTake[k][i] = 1'b1;
						selCode = classMsg(k);
						selArg = {11'h000, capNum_reg[i]}; // RULE10
						selUdp = lastUdp_reg; // RULE11
					end
				end
			end
		end
		if (txState_reg != TX_IDLE)
			pendTake = '0;
		pend_next = (pend_reg & ~pendTake) | pendSet;
		romCode = (txState_reg == TX_IDLE) ? selCode : code_reg;
		romIdx = (txState_reg == TX_IDLE) ? 6'h00 : idx_reg + 6'h01;
	end

	lceh_msg_rom u_rom (
		.code   (romCode),
		.idx    (romIdx),
		.argBin ((txState_reg == TX_IDLE) ? selArg : arg_reg),
		.ch     (romCh),
		.last   (romLast)
	);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pend_reg <= '0;
			txState_reg <= TX_IDLE;
			code_reg <= MSG_INVALID;
			arg_reg <= 16'h0000;
			idx_reg <= 6'h00;
			txValid <= 1'b0;
			txOut <= '0;
			txLast_reg <= 1'b0;
		end
		else
		begin
			pend_reg <= pend_next;
			case (txState_reg)
				TX_IDLE:
				begin
					if (selAny)
					begin
						txState_reg <= TX_SEND;
						code_reg <= selCode;
						arg_reg <= selArg;
						idx_reg <= 6'h00;
						txValid <= 1'b1;
						txOut <= '{data: romCh, udp: selUdp}; // RULE1
						txLast_reg <= romLast;
					end
				end
				TX_SEND:
				begin
					if (txReady)
					begin
						if (txLast_reg)
						begin
							txState_reg <= TX_IDLE;
							txValid <= 1'b0;
						end
						else
						begin
							idx_reg <= romIdx;
							txOut.data <= romCh;
							txLast_reg <= romLast;
						end
					end
				end
				default: txState_reg <= TX_IDLE;
			endcase
		end
	end

	chk_prefix_colon: assert property (@(posedge clk) disable iff (rst) $rose(txValid) |-> txOut.data == 8'h3A) // RULE1
		else $error("report does not start with colon");
	chk_reject_reply: assert property (@(posedge clk) disable iff (rst) cmdAcc && cmdErr |=> replyPend_reg) // RULE2
		else $error("rejected command got no reply");
	chk_no_commit: assert property (@(posedge clk) disable iff (rst) // RULE3
		cmdAcc && cmdErr |=> $stable(softCur_reg) && $stable(curLim_reg) && $stable(voltLim_reg))
		else $error("rejected command changed configuration");
	chk_all_commit: assert property (@(posedge clk) disable iff (rst) // RULE4
		cmdOk && cmdIn.setCurr && cmdIn.setVolt |=> softCur_reg[$past(ci)] == $past(cmdIn.curr)
		&& voltLim_reg[$past(ci)] == $past(cmdIn.volt))
		else $error("valid command not fully committed");
	chk_limit_code: assert property (@(posedge clk) disable iff (rst) // RULE5
		cmdAcc && chanOk && !errMode_reg[ci] && !cmdBad && cmdTooBig |=> replyCode_reg == MSG_LIMIT
		&& replyArg_reg == $past(effLimit))
		else $error("over-limit current not reported with limit");
	chk_ot_cut: assert property (@(posedge clk) disable iff (rst) errMode_reg[NCH-1] |=> outCurrent[NCH-1] == 16'h0000) // RULE6
		else $error("current not cut in error mode");
	chk_errmode_refuse: assert property (@(posedge clk) disable iff (rst) // RULE8
		cmdAcc && chanOk && errMode_reg[ci] |-> cmdErr && cmdCode == MSG_ERRMODE)
		else $error("configuration accepted in error mode");
	chk_cool_dark: assert property (@(posedge clk) disable iff (rst) // RULE9
		!errMode_reg[NCH-1] && !dup_reg[NCH-1] |=> !ledRed[NCH-1])
		else $error("red flashing without error");
	chk_lastif_track: assert property (@(posedge clk) disable iff (rst) cmdOk |=> lastUdp_reg == $past(cmdIn.udp)) // RULE11
		else $error("last interface not tracked");
	chk_dup_hold: assert property (@(posedge clk) disable iff (rst) !$fell(dup_reg[0])) // RULE13
		else $error("duplicate flag cleared before reset");
	chk_ot_pend: assert property (@(posedge clk) disable iff (rst) // RULE7
		$rose(errMode_reg[NCH-1]) |-> ##[0:1] (pend_reg[1][NCH-1] || txState_reg == TX_SEND))
		else $error("overtemperature not queued for report");
	cov_overtemp: cover property (@(posedge clk) disable iff (rst)
		$rose(errMode_reg[NCH-1]) ##[1:1000] $fell(errMode_reg[NCH-1]));
	cov_reject: cover property (@(posedge clk) disable iff (rst) cmdAcc && cmdCode == MSG_LIMIT && cmdErr);
	cov_report_done: cover property (@(posedge clk) disable iff (rst) txValid && txReady && txLast_reg);
endmodule // lceh_error_handler

// ==== lceh_host_model.sv ====
/*
 Host model at the far side of the report stream: takes bytes with random stalls, ready about three cycles in four.
 Assumes the handler's report framing ends each report with a prompt byte.
*/
module lceh_host_model
	import lceh_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire lceh_tx_t txOut,
	input  wire logic     txValid,
	output logic          txReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] msg[$];
	logic [7:0] part[$];
	logic       msgUdp = 1'b0;
	int         nMsg = 0;
	initial txReady = 1'b0;
	// Random stalls so slow and prompt draining both occur
	always @(posedge clk)
	begin
		txReady <= !rst && ($urandom_range(3) != 0);
		if (rst)
			part.delete();
		else if (txValid && txReady)
		begin
			part.push_back(txOut.data);
			if (txOut.data == 8'h3E)
			begin
				msg = part;
				msgUdp = txOut.udp;
				part.delete();
				nMsg++;
			end
		end
	end
endmodule // lceh_host_model

// ==== lceh_msg_rom.sv ====
/*
 Character generator for framed error reports: template text with digit
 slots filled from a binary argument. Purely combinational.
*/
module lceh_msg_rom
	import lceh_pkg::*;
(
	input  wire lceh_msg_t   code,
	input  wire logic [5:0]  idx,
	input  wire logic [15:0] argBin,
	output logic      [7:0]  ch,
	output logic             last
);
	function automatic logic [19:0] toBcd(input logic [15:0] bin);
		logic [35:0] sh;
		sh = {20'h00000, bin};
		for (int i = 0; i < 16; i++)
		begin
			for (int d = 0; d < 5; d++)
			begin
				if (sh[16 + 4 * d +: 4] > 4'h4)
					sh[16 + 4 * d +: 4] = sh[16 + 4 * d +: 4] + 4'h3;
			end
			sh = {sh[34:0], 1'b0};
		end
		return sh[35:16];
	endfunction

	logic [MSG_BITS-1:0] tmpl;
	logic [19:0]         bcd;
	logic [7:0]          raw;
	int                  len;

	always_comb
	begin
		// Byte values 01..05 are digit slots, most significant first
		case (code)
			MSG_INVALID:  tmpl = MSG_BITS'({":E Invalid parameter", "\r\n>"});
			MSG_LIMIT:    tmpl = MSG_BITS'({":E Current above limit, max ",
				8'h01, 8'h02, 8'h03, 8'h04, 8'h05, " mA\r\n>"});
			MSG_ERRMODE:  tmpl = MSG_BITS'({":E Channel in error mode", "\r\n>"});
			MSG_OVERTEMP: tmpl = MSG_BITS'({":E Overtemperature channel ", 8'h04, 8'h05, "\r\n>"});
			MSG_CHANCHG:  tmpl = MSG_BITS'({":E Channel number changed ", 8'h04, 8'h05, "\r\n>"});
			MSG_DUP:      tmpl = MSG_BITS'({":E Duplicate channel number ", 8'h04, 8'h05, "\r\n>"});
			MSG_VOLTLOW:  tmpl = MSG_BITS'({":E Voltage limit too low channel ", 8'h04, 8'h05, "\r\n>"});
			default:      tmpl = MSG_BITS'({":E Invalid parameter", "\r\n>"});
		endcase
		len = 0;
		for (int k = 0; k < MSG_BYTES; k++)
		begin
			if (tmpl[8 * k +: 8] != 8'h00)
				len = k + 1;
		end
		bcd = toBcd(argBin);
		raw = (int'(idx) < len) ? tmpl[8 * (len - 1 - int'(idx)) +: 8] : 8'h00;
		if (raw >= 8'h01 && raw <= 8'h05)
			ch = {4'h3, bcd[4 * (5 - int'(raw)) +: 4]};
		else
			ch = raw;
		last = (int'(idx) == len - 1);
	end
endmodule // lceh_msg_rom

// ==== lceh_pkg.sv ====
/*
 Shared constants, message codes and carrier types of the light-controller
 error handler. Assumes a 250 MHz system clock and AXI4-Lite register access.
*/
package lceh_pkg;
	localparam int          CLK_MHZ        = 250;
	localparam int          FLASH_HALF_MS  = 250;
	localparam int          FLASH_CYCLES   = FLASH_HALF_MS * 1000 * CLK_MHZ;
	localparam int          MAX_CURRENT_MA = 20000;
	localparam int          VOLT_MAX_MV    = 48000;
	localparam logic [15:0] VOLT_LIM_RST   = 16'h61A8;
	localparam logic [15:0] CUR_MARGIN_MA  = 16'h000A;
	localparam logic [7:0]  ADDR_STATUS    = 8'h00;
	localparam logic [7:0]  ADDR_MASK      = 8'h04;
	localparam logic [7:0]  ADDR_TLIM      = 8'h08;
	localparam logic [7:0]  ADDR_THYS      = 8'h0C;
	localparam logic [7:0]  ADDR_STATE     = 8'h10;
	localparam logic [7:0]  TLIM_RST       = 8'h55;
	localparam logic [7:0]  THYS_RST       = 8'h0A;
	localparam int          EV_REJECT      = 0;
	localparam int          EV_OVERTEMP    = 1;
	localparam int          EV_CHANCHG     = 2;
	localparam int          EV_DUP         = 3;
	localparam int          EV_VOLTLOW     = 4;
	localparam int          EV_COOLED      = 5;
	localparam int          EV_W           = 6;
	localparam int          STATE_UDP_BIT  = 16;
	localparam int          STATE_BUSY_BIT = 17;
	localparam int          MSG_BYTES      = 48;
	localparam int          MSG_BITS       = MSG_BYTES * 8;

	typedef enum logic [2:0] {
		MSG_INVALID  = 3'b000,
		MSG_LIMIT    = 3'b001,
		MSG_ERRMODE  = 3'b010,
		MSG_OVERTEMP = 3'b011,
		MSG_CHANCHG  = 3'b100,
		MSG_DUP      = 3'b101,
		MSG_VOLTLOW  = 3'b110
	} lceh_msg_t;

	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} lceh_txst_t;

	typedef struct packed {
		logic        udp;
		logic [3:0]  chan;
		logic        setLimit;
		logic [15:0] limit;
		logic        setCurr;
		logic [15:0] curr;
		logic        setVolt;
		logic [15:0] volt;
	} lceh_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic       udp;
	} lceh_tx_t;
endpackage

// ==== tb.sv ====
/*
 Bench of the error handler: register access, commands, reports, events.
 Assumes lceh_pkg and the host model are compiled first.
*/
module tb
	import lceh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk = 1'b0, rst = 1'b1;
	logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic             arvalid = 1'b0, rready = 1'b0, cmdValid = 1'b0;
	logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]      wdata = 32'h0, rdata;
	logic [3:0]       wstrb = 4'hF;
	logic [1:0]       bresp, rresp;
	logic             awready, wready, bvalid, arready, rvalid, cmdReady, txValid, txReady, irq;
	lceh_cmd_t        cmdIn = '0;
	lceh_tx_t         txOut;
	logic [1:0][7:0]  tempC = {8'h1E, 8'h1E};
	logic [1:0][4:0]  chanNumSw = {5'h02, 5'h01};
	logic [1:0][15:0] meas = '0, outCurrent;
	logic [1:0]       ledRed;
	int               fail_count = 0, checked = 0, cyc = 0, seen = 0;

	lceh_error_handler #(
		.NCH       (2),
		.FLASH_CYC (8)
	) u_lceh_error_handler (
		.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cmdIn, .cmdValid, .cmdReady,
		.tempC, .chanNumSw, .measCurrent(meas), .measVolt(meas), .txOut, .txValid, .txReady, .outCurrent,
		.ledRed, .irq
	);
	lceh_host_model u_host (.clk, .rst, .txOut, .txValid, .txReady);

	initial forever #2 clk = ~clk;

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic string limTxt(input int l);
		return $sformatf("Current above limit, max %05d mA", l);
	endfunction

	function automatic string chTxt(input string s, input int n);
		return $sformatf("%s %02d", s, n);
	endfunction

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw = 0, w = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			aw |= awready;
			w |= wready;
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end
		while (!(aw && w));
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		chk(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		chk(rdata & m, e);
		chk(rresp, er);
	endtask

	task automatic cmd(input logic [3:0] ch, input logic [15:0] l, c, v, input logic [2:0] f, input logic u);
		cmdIn <= '{u, ch, f[2], l, f[1], c, f[0], v};
		cmdValid <= 1'b1;
		do @(posedge clk); while (!cmdReady);
		cmdValid <= 1'b0;
	endtask

	task automatic quiet(input int n);
		repeat (n) @(posedge clk);
		chk(u_host.nMsg, seen);
	endtask

	task automatic wait_msg(input string s, input logic u);
		string e;
		int n = 0;
		e = {":E ", s, "\r\n>"};
		while (u_host.nMsg == seen && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		seen = u_host.nMsg;
		chk(n < 2000, 1'b1);
		chk(u_host.msg.size(), e.len());
		for (int i = 0; i < e.len(); i++)
			chk(u_host.msg[i], e[i]);
		chk(u_host.msgUdp, u);
	endtask

	task automatic flashes(input int i, input logic e);
		int t = 0;
		logic p;
		p = ledRed[i];
		repeat (40)
		begin
			@(posedge clk);
			t += (ledRed[i] !== p);
			p = ledRed[i];
		end
		chk(t != 0, e);
	endtask

	initial
	begin
		logic [15:0] l, c;
		void'($urandom(32'hCDF6));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(ADDR_TLIM, 32'hFF, {24'h0, TLIM_RST}, 2'h0);
		rd(ADDR_THYS, 32'hFF, {24'h0, THYS_RST}, 2'h0);
		rd(ADDR_MASK, 32'hFFFFFFFF, 32'h0, 2'h0);
		rd(ADDR_STATUS, 32'hFFFFFFFF, 32'h0, 2'h0);
		rd(8'h40, 32'hFFFFFFFF, 32'h0, 2'h2);
		wr(8'h40, 32'h1, 2'h2);
		// Byte lane 0 off: the write must be dropped
		wstrb <= 4'h0;
		wr(ADDR_TLIM, 32'h0, 2'h0);
		wstrb <= 4'hF;
		rd(ADDR_TLIM, 32'hFF, {24'h0, TLIM_RST}, 2'h0);
		wr(ADDR_MASK, 32'h3F, 2'h0);
		cmd(4'h0, 16'h03E8, 16'h0, 16'h0, 3'h4, 1'b0);
		quiet(40);
		cmd(4'h0, 16'h0, 16'h03E9, 16'h0, 3'h2, 1'b0);
		wait_msg(limTxt(1000), 1'b0);
		chk(irq, 1'b1);
		rd(ADDR_STATUS, 32'h1, 32'h1, 2'h0);
		wr(ADDR_STATUS, 32'h1, 2'h0);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		cmd(4'h0, 16'h01F4, 16'h0, 16'hC350, 3'h5, 1'b0);
		wait_msg("Invalid parameter", 1'b0);
		// Would be refused had the 500 mA limit leaked in
		cmd(4'h0, 16'h0, 16'h0384, 16'h0, 3'h2, 1'b0);
		quiet(40);
		chk(outCurrent[0], 16'h0384);
		cmd(4'h5, 16'h0064, 16'h0, 16'h0, 3'h4, 1'b0);
		wait_msg("Invalid parameter", 1'b0);
		cmd(4'h0, 16'h0, 16'h0, 16'h0, 3'h0, 1'b0);
		wait_msg("Invalid parameter", 1'b0);
		for (int k = 0; k < 6; k++)
		begin
			l = 16'($urandom_range(20000, 1));
			c = 16'($urandom_range(l, 0));
			cmd(4'h0, l, c, 16'($urandom_range(48000, 1)), 3'h7, k[0]);
			quiet(30);
			chk(outCurrent[0], c);
		end
		// Voltage limit 0 with measured current 0 trips the low-limit check
		cmd(4'h0, 16'h07D0, 16'h03E8, 16'h0, 3'h7, 1'b0);
		wait_msg(chTxt("Voltage limit too low channel", 1), 1'b0);
		cmd(4'h1, 16'h07D0, 16'h05DC, 16'h0, 3'h6, 1'b1);
		quiet(30);
		chk(outCurrent[1], 16'h05DC);
		tempC[1] <= 8'h56;
		wait_msg(chTxt("Overtemperature channel", 2), 1'b1);
		chk(outCurrent[1], 16'h0);
		flashes(1, 1'b1);
		cmd(4'h1, 16'h0, 16'h0064, 16'h0, 3'h2, 1'b1);
		wait_msg("Channel in error mode", 1'b1);
		tempC[1] <= 8'h4C;
		repeat (10) @(posedge clk);
		rd(ADDR_STATE, 32'h3, 32'h2, 2'h0);
		tempC[1] <= 8'h4B;
		repeat (10) @(posedge clk);
		rd(ADDR_STATE, 32'h3, 32'h0, 2'h0);
		rd(ADDR_STATUS, 32'h22, 32'h22, 2'h0);
		flashes(1, 1'b0);
		chk(ledRed[1], 1'b0);
		cmd(4'h1, 16'h0, 16'h0064, 16'h0, 3'h2, 1'b1);
		quiet(30);
		chk(outCurrent[1], 16'h0064);
		chanNumSw[0] <= 5'h04;
		wait_msg(chTxt("Channel number changed", 1), 1'b1);
		rd(ADDR_STATUS, 32'h4, 32'h4, 2'h0);
		chanNumSw <= {5'h03, 5'h03};
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wait_msg(chTxt("Duplicate channel number", 3), 1'b0);
		wait_msg(chTxt("Duplicate channel number", 3), 1'b0);
		flashes(0, 1'b1);
		// A stored nonzero current must still be held off
		cmd(4'h0, 16'h03E8, 16'h01F4, 16'h0, 3'h6, 1'b0);
		repeat (3) @(posedge clk);
		chk(outCurrent[0], 16'h0);
		give_verdict();
	end
endmodule // tb
